// ### rtl/fpecs_sequencer.sv
`timescale 1ns/1ps
module fpecs_sequencer #(
  parameter int COLLECT_LIMIT = fpecs_pkg::COLLECT_CYCLES
) (
  input  wire logic                    CLOCK_IN,
  input  wire logic                    RST_B_IN,
  input  wire logic                    WB_CYC_IN,
  input  wire logic                    WB_STB_IN,
  input  wire logic                    WB_WE_IN,
  input  wire logic [7:0]              WB_ADR_IN,
  input  wire logic [3:0]              WB_SEL_IN,
  input  wire logic [31:0]             WB_DAT_IN,
  output logic [31:0]                  WB_DAT_OUT,
  output logic                         WB_ACK_OUT,
  output logic [fpecs_pkg::ADDR_W-1:0] FLASH_ADDR_OUT,
  input  wire logic [fpecs_pkg::DATA_W-1:0] FLASH_DQ_IN,
  output logic [fpecs_pkg::DATA_W-1:0] FLASH_DQ_OUT,
  output logic                         FLASH_DQ_OE_B_OUT,
  output logic                         FLASH_CE_B_OUT,
  output logic                         FLASH_WE_B_OUT,
  output logic                         FLASH_OE_B_OUT,
  output logic                         FLASH_RESET_B_OUT,
  output logic                         FLASH_BYTE_B_OUT,
  output logic                         FLASH_ACCEL_HIGH_OUT,
  input  wire logic                    FLASH_READY_BUSY_N_IN
);
  import fpecs_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_HWRST} fpecs_state_type;

  fpecs_state_type state_q;
  fpecs_op_type    op_q;
  fpecs_cycle_type step_c;
  logic [31:0] ctrl_q, addr_q, data_q, rdata_q;
  logic [2:0]  idx_q, wcount_q;
  logic [7:0]  rst_cnt_q, settle_q;
  logic [15:0] win_cnt_q;
  logic        emb_q, byp_q, sec_q, win_q, susp_q, refused_q, accel_q;
  logic        acc, cmd_go, legal, leaf_done, seq_fin, req_valid, late, byp_any;
  logic [DATA_W-1:0] leaf_rdata;
  fpecs_op_type cmd_op;

  // merge a write into a register by byte lanes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        old_v[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return old_v;
  endfunction

  // number of flash bus cycles in each operation
  function automatic logic [2:0] seq_len(input fpecs_op_type op);
    case (op)
      OP_PROGRAM, OP_SEC_EXIT:         return 3'd4;
      OP_BYP_ENTER, OP_SEC_ENTER:      return 3'd3;
      OP_BYP_PROGRAM, OP_BYP_EXIT:     return 3'd2;
      OP_CHIP_ERASE, OP_SECTOR_ERASE:  return 3'd6;
      default:                         return 3'd1;
    endcase
  endfunction

  // address and data of one step of an operation
  function automatic fpecs_cycle_type seq_step(input fpecs_op_type op, input logic [2:0] idx,
                                               input logic bm, input logic [ADDR_W-1:0] ta,
                                               input logic [DATA_W-1:0] td);
    fpecs_cycle_type c;
    logic [ADDR_W-1:0] ua, ub;
    logic erase, multi;
    ua = {ta[ADDR_W-1:12], bm ? UNL_A_BYTE : UNL_A_WORD};
    ub = {ta[ADDR_W-1:12], bm ? UNL_B_BYTE : UNL_B_WORD};
    erase = (op == OP_CHIP_ERASE) || (op == OP_SECTOR_ERASE);
    multi = erase || (op == OP_PROGRAM) || (op == OP_BYP_ENTER) || (op == OP_SEC_ENTER) ||
            (op == OP_SEC_EXIT);
    c = '{write: 1'b1, addr: ta, data: {8'h00, CMD_RESET}};
    if (multi && (idx == 3'd0 || (erase && idx == 3'd3))) begin
      c.addr = ua;
      c.data = {8'h00, CMD_UNLOCK_A};
    end else if (multi && (idx == 3'd1 || (erase && idx == 3'd4))) begin
      c.addr = ub;
      c.data = {8'h00, CMD_UNLOCK_B};
    end else if (multi && idx == 3'd2) begin
      c.addr = ua;
      case (op)
        OP_PROGRAM:   c.data = {8'h00, CMD_PROGRAM};
        OP_BYP_ENTER: c.data = {8'h00, CMD_BYPASS};
        OP_SEC_ENTER: c.data = {8'h00, CMD_SECURE};
        OP_SEC_EXIT:  c.data = {8'h00, CMD_EXIT};
        default:      c.data = {8'h00, CMD_SETUP};
      endcase
    end else begin
      case (op)
        OP_READ:         c.write = 1'b0;
        OP_PROGRAM:      c.data = td;
        OP_BYP_PROGRAM:  c.data = (idx == 3'd0) ? {8'h00, CMD_PROGRAM} : td;
        OP_BYP_EXIT:     c.data = (idx == 3'd0) ? {8'h00, CMD_EXIT} : {8'h00, CMD_ZERO};
        OP_SEC_EXIT:     c.data = {8'h00, CMD_ZERO};
        OP_CHIP_ERASE: begin
          c.addr = ua;
          c.data = {8'h00, CMD_CHIP};
        end
        OP_SECTOR_ERASE, OP_SECTOR_ADD, OP_RESUME: c.data = {8'h00, CMD_SECTOR};
        OP_SUSPEND:      c.data = {8'h00, CMD_SUSPEND};
        default:         c.data = {8'h00, CMD_RESET};
      endcase
    end
    return c;
  endfunction

  // whether an operation may be sent in the present mode
  function automatic logic op_legal(input fpecs_op_type op, input logic emb, input logic byp,
                                    input logic sec, input logic win, input logic lt,
                                    input logic susp);
    case (op)
      OP_READ, OP_HW_RESET: return 1'b1;
      OP_SUSPEND:           return emb && !susp || win;
      default: begin
        if (emb) return 1'b0;
        case (op)
          OP_BYP_PROGRAM: return byp && !sec;
          OP_BYP_EXIT:    return byp;
          default: begin
            if (byp) return 1'b0;
            case (op)
              OP_BYP_ENTER:  return !sec;
              OP_SECTOR_ADD: return win && !lt;
              OP_RESUME:     return susp;
              default:       return 1'b1;
            endcase
          end
        endcase
      end
    endcase
  endfunction

  assign acc       = WB_CYC_IN && WB_STB_IN && WB_ACK_OUT;
  assign cmd_go    = acc && WB_WE_IN && WB_ADR_IN == OFS_CMD && WB_SEL_IN[0];
  assign cmd_op    = fpecs_op_type'(WB_DAT_IN[3:0]);
  assign late      = win_cnt_q >= 16'(COLLECT_LIMIT - MARGIN_CYCLES);
  assign byp_any   = byp_q || accel_q;
  assign legal     = (WB_DAT_IN[3:0] <= 4'(OP_HW_RESET)) && state_q == S_IDLE &&
                     op_legal(cmd_op, emb_q, byp_any, sec_q, win_q, late, susp_q);
  assign req_valid = state_q == S_ISSUE;
  assign step_c    = seq_step(op_q, idx_q, ctrl_q[CTRL_BYTE_BIT], addr_q[ADDR_W-1:0],
                              data_q[DATA_W-1:0]);
  assign seq_fin   = state_q == S_WAIT && leaf_done && idx_q == seq_len(op_q) - 3'd1;

  // wishbone acknowledge, one cycle after the request is seen
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
    end else begin
      WB_ACK_OUT <= WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
      case (WB_ADR_IN)
        OFS_CTRL:   WB_DAT_OUT <= ctrl_q;
        OFS_CMD:    WB_DAT_OUT <= {27'h0, refused_q, 4'(op_q)};
        OFS_ADDR:   WB_DAT_OUT <= addr_q;
        OFS_DATA:   WB_DAT_OUT <= rdata_q;
        OFS_STATUS: WB_DAT_OUT <= {22'h0, accel_q, susp_q, late, win_q, sec_q, byp_any, emb_q,
                                   !FLASH_READY_BUSY_N_IN, state_q != S_IDLE, refused_q};
        default:    WB_DAT_OUT <= 32'h0000_0000;
      endcase
    end
  end

  // software registers, taken at the acknowledge edge
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      ctrl_q    <= CTRL_RESET;
      addr_q    <= ADDR_RESET;
      data_q    <= DATA_RESET;
      refused_q <= 1'b0;
    end else if (acc && WB_WE_IN) begin
      if (WB_ADR_IN == OFS_CTRL) ctrl_q <= lane_merge(ctrl_q, WB_DAT_IN, WB_SEL_IN);
      if (WB_ADR_IN == OFS_ADDR) addr_q <= lane_merge(addr_q, WB_DAT_IN, WB_SEL_IN);
      if (WB_ADR_IN == OFS_DATA) data_q <= lane_merge(data_q, WB_DAT_IN, WB_SEL_IN);
      if (cmd_go) refused_q <= !legal;
    end
  end

  // sequence engine: one leaf bus cycle per step
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      state_q   <= S_IDLE;
      op_q      <= OP_READ;
      idx_q     <= 3'd0;
      wcount_q  <= 3'd0;
      rst_cnt_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (cmd_go && legal) begin
            op_q     <= cmd_op;
            idx_q    <= 3'd0;
            wcount_q <= 3'd0;
            if (cmd_op == OP_HW_RESET) begin
              rst_cnt_q <= 8'(RESET_CYCLES);
              state_q   <= S_HWRST;
            end else begin
              state_q <= S_ISSUE;
            end
          end
        end
        S_ISSUE: state_q <= S_WAIT;
        S_WAIT: begin
          if (leaf_done) begin
            if (step_c.write) wcount_q <= wcount_q + 3'd1;
            else rdata_q <= {16'h0, leaf_rdata};
            if (seq_fin) state_q <= S_IDLE;
            else begin
              idx_q   <= idx_q + 3'd1;
              state_q <= S_ISSUE;
            end
          end
        end
        S_HWRST: begin
          if (rst_cnt_q <= 8'h01) state_q <= S_IDLE;
          else rst_cnt_q <= rst_cnt_q - 8'h01;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // secured region about to be selected by the finishing sequence
  function automatic logic sec_c_next();
    return seq_fin && op_q == OP_SEC_ENTER;
  endfunction

  // reset, width and accelerate pins
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      FLASH_RESET_B_OUT    <= 1'b1;
      FLASH_BYTE_B_OUT     <= 1'b1;
      FLASH_ACCEL_HIGH_OUT <= 1'b0;
      accel_q              <= 1'b0;
    end else begin
      FLASH_RESET_B_OUT    <= !(state_q == S_HWRST && rst_cnt_q > 8'h01);
      FLASH_BYTE_B_OUT     <= !ctrl_q[CTRL_BYTE_BIT];
      accel_q              <= ctrl_q[CTRL_ACCEL_BIT] && !sec_q && !sec_c_next();
      FLASH_ACCEL_HIGH_OUT <= ctrl_q[CTRL_ACCEL_BIT] && !sec_q && !sec_c_next();
    end
  end

  // device mode tracking from finished sequences
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_B_IN) begin
      emb_q     <= 1'b0;
      byp_q     <= 1'b0;
      sec_q     <= 1'b0;
      win_q     <= 1'b0;
      susp_q    <= 1'b0;
      win_cnt_q <= 16'h0000;
      settle_q  <= 8'h00;
    end else if (state_q == S_HWRST) begin
      {emb_q, byp_q, sec_q, win_q, susp_q} <= 5'b00000;
    end else begin
      if (settle_q != 8'h00) settle_q <= settle_q - 8'h01;
      else if (emb_q && FLASH_READY_BUSY_N_IN) emb_q <= 1'b0;
      if (win_q) begin
        win_cnt_q <= win_cnt_q + 16'h0001;
        if (win_cnt_q >= 16'(COLLECT_LIMIT - 1)) begin
          win_q    <= 1'b0;
          emb_q    <= 1'b1;
          settle_q <= 8'(SETTLE_CYCLES);
        end
      end
      if (seq_fin) begin
        case (op_q)
          OP_PROGRAM, OP_BYP_PROGRAM, OP_CHIP_ERASE, OP_RESUME: begin
            emb_q    <= 1'b1;
            settle_q <= 8'(SETTLE_CYCLES);
            if (op_q == OP_RESUME) susp_q <= 1'b0;
          end
          OP_SECTOR_ERASE, OP_SECTOR_ADD: begin
            win_q     <= 1'b1;
            win_cnt_q <= 16'h0000;
          end
          OP_SUSPEND: begin
            {win_q, emb_q} <= 2'b00;
            susp_q         <= 1'b1;
          end
          OP_BYP_ENTER: byp_q <= 1'b1;
          OP_BYP_EXIT:  byp_q <= 1'b0;
          OP_SEC_ENTER: sec_q <= 1'b1;
          OP_SEC_EXIT:  sec_q <= 1'b0;
          default: ;
        endcase
        if (op_q != OP_READ && op_q != OP_SECTOR_ERASE && op_q != OP_SECTOR_ADD &&
            op_q != OP_SUSPEND) begin
          win_q <= 1'b0;
        end
      end
    end
  end

  fpecs_flash_cycle u_cycle (
    .clk_in      (CLOCK_IN),
    .rst_b_in    (RST_B_IN),
    .req_valid_in(req_valid),
    .req_in      (step_c),
    .done_out    (leaf_done),
    .rdata_out   (leaf_rdata),
    .addr_out    (FLASH_ADDR_OUT),
    .dq_out      (FLASH_DQ_OUT),
    .dq_oe_b_out (FLASH_DQ_OE_B_OUT),
    .dq_in       (FLASH_DQ_IN),
    .ce_b_out    (FLASH_CE_B_OUT),
    .we_b_out    (FLASH_WE_B_OUT),
    .oe_b_out    (FLASH_OE_B_OUT)
  );

  chk_program_writes: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    seq_fin && op_q == OP_PROGRAM |-> wcount_q == 3'd3)
    else $error("program sequence did not issue four writes");
  chk_erase_writes: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    seq_fin && (op_q == OP_CHIP_ERASE || op_q == OP_SECTOR_ERASE) |-> wcount_q == 3'd5)
    else $error("erase sequence did not issue six writes");
  chk_bypass_writes: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    seq_fin && op_q == OP_BYP_PROGRAM |-> wcount_q == 3'd1 && byp_any)
    else $error("bypass program not two writes in bypass");
  chk_secure_exit: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    seq_fin && op_q == OP_SEC_EXIT |-> wcount_q == 3'd3 ##1 !sec_q)
    else $error("secured exit wrong length or mode kept");
  chk_secure_accel: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    sec_q && $past(sec_q) |-> !FLASH_ACCEL_HIGH_OUT && !accel_q)
    else $error("accelerate driven while secured region selected");
  chk_bypass_only: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    byp_any && cmd_go && legal |-> cmd_op inside {OP_BYP_PROGRAM, OP_BYP_EXIT, OP_READ,
                                                   OP_HW_RESET})
    else $error("command accepted in bypass mode");
  chk_busy_refuse: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    emb_q && cmd_go && legal |-> cmd_op inside {OP_READ, OP_SUSPEND, OP_HW_RESET})
    else $error("command accepted during embedded operation");
  chk_window_open: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    seq_fin && op_q == OP_SECTOR_ERASE |=> win_q && win_cnt_q == 16'h0000)
    else $error("collection window not opened after sector erase");
  chk_sector_late: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    cmd_go && cmd_op == OP_SECTOR_ADD && (!win_q || late) |=> refused_q)
    else $error("sector add outside safe window not refused");
  chk_first_unlock: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    req_valid && idx_q == 3'd0 && op_q == OP_PROGRAM |-> step_c.data[7:0] == CMD_UNLOCK_A)
    else $error("program sequence not opened by unlock");

endmodule // fpecs_sequencer

// ### rtl/fpecs_pkg.sv
package fpecs_pkg;

  // clock and flash bus widths
  localparam int CLK_MHZ = 125;
  localparam int ADDR_W  = 22;
  localparam int DATA_W  = 16;

  // bus timing on the flash pins, in ns, and derived cycle counts (rounded up)
  localparam int T_STROBE_NS  = 40;
  localparam int T_ACCESS_NS  = 80;
  localparam int T_RESET_NS   = 500;
  localparam int T_SETTLE_NS  = 200;
  localparam int STROBE_CYCLES = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int ACCESS_CYCLES = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_CYCLES  = (T_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_CYCLES = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;

  // sector collection window, longest time, rounded down
  localparam int T_COLLECT_US   = 50;
  localparam int COLLECT_CYCLES = T_COLLECT_US * CLK_MHZ;
  localparam int T_MARGIN_NS    = 2000;
  localparam int MARGIN_CYCLES  = (T_MARGIN_NS * CLK_MHZ) / 1000;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_ADDR   = 8'h08;
  localparam logic [7:0] OFS_DATA   = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // control fields and reset values
  localparam int CTRL_BYTE_BIT  = 0;
  localparam int CTRL_ACCEL_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

  // command codes
  localparam logic [7:0] CMD_UNLOCK_A = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
  localparam logic [7:0] CMD_PROGRAM  = 8'hA0;
  localparam logic [7:0] CMD_BYPASS   = 8'h20;
  localparam logic [7:0] CMD_EXIT     = 8'h90;
  localparam logic [7:0] CMD_ZERO     = 8'h00;
  localparam logic [7:0] CMD_SETUP    = 8'h80;
  localparam logic [7:0] CMD_CHIP     = 8'h10;
  localparam logic [7:0] CMD_SECTOR   = 8'h30;
  localparam logic [7:0] CMD_SUSPEND  = 8'hB0;
  localparam logic [7:0] CMD_SECURE   = 8'h88;
  localparam logic [7:0] CMD_RESET    = 8'hF0;

  // unlock addresses, low twelve bits
  localparam logic [11:0] UNL_A_WORD = 12'h555;
  localparam logic [11:0] UNL_B_WORD = 12'h2AA;
  localparam logic [11:0] UNL_A_BYTE = 12'hAAA;
  localparam logic [11:0] UNL_B_BYTE = 12'h555;

  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_PROGRAM, OP_BYP_ENTER, OP_BYP_PROGRAM, OP_BYP_EXIT,
    OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SECTOR_ADD, OP_SUSPEND, OP_RESUME,
    OP_SEC_ENTER, OP_SEC_EXIT, OP_HW_RESET
  } fpecs_op_type;

  // one flash bus cycle
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fpecs_cycle_type;

endpackage

// ### rtl/fpecs_flash_cycle.sv
`timescale 1ns/1ps
module fpecs_flash_cycle (
  input  wire logic                    clk_in,
  input  wire logic                    rst_b_in,
  input  wire logic                    req_valid_in,
  input  fpecs_pkg::fpecs_cycle_type   req_in,
  output logic                         done_out,
  output logic [fpecs_pkg::DATA_W-1:0] rdata_out,
  output logic [fpecs_pkg::ADDR_W-1:0] addr_out,
  output logic [fpecs_pkg::DATA_W-1:0] dq_out,
  output logic                         dq_oe_b_out,
  input  wire logic [fpecs_pkg::DATA_W-1:0] dq_in,
  output logic                         ce_b_out,
  output logic                         we_b_out,
  output logic                         oe_b_out
);
  import fpecs_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} fpecs_cyc_state_type;

  fpecs_cyc_state_type state_q;
  logic [7:0]          cnt_q;
  logic                write_q;

  // one strobe cycle: chip select, then write or output strobe, then release
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_q     <= C_IDLE;
      cnt_q       <= 8'h00;
      write_q     <= 1'b0;
      done_out    <= 1'b0;
      rdata_out   <= '0;
      addr_out    <= '0;
      dq_out      <= '0;
      dq_oe_b_out <= 1'b1;
      ce_b_out    <= 1'b1;
      we_b_out    <= 1'b1;
      oe_b_out    <= 1'b1;
    end else begin
      done_out <= 1'b0;
      case (state_q)
        C_IDLE: begin
          if (req_valid_in) begin
            addr_out    <= req_in.addr;
            dq_out      <= req_in.data;
            dq_oe_b_out <= !req_in.write;
            write_q     <= req_in.write;
            ce_b_out    <= 1'b0;
            state_q     <= C_SETUP;
          end
        end
        C_SETUP: begin
          // strobe falls after chip select, so the address is taken here
          we_b_out <= !write_q;
          oe_b_out <= write_q;
          cnt_q    <= write_q ? 8'(STROBE_CYCLES) : 8'(ACCESS_CYCLES);
          state_q  <= C_STROBE;
        end
        C_STROBE: begin
          if (cnt_q <= 8'h01) begin
            // write strobe rises first, data is taken on that edge
            we_b_out <= 1'b1;
            oe_b_out <= 1'b1;
            if (!write_q) begin
              rdata_out <= dq_in;
            end
            state_q <= C_HOLD;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        C_HOLD: begin
          ce_b_out    <= 1'b1;
          dq_oe_b_out <= 1'b1;
          done_out    <= 1'b1;
          state_q     <= C_IDLE;
        end
        default: state_q <= C_IDLE;
      endcase
    end
  end

  // write strobe only ever pulses inside chip select
  chk_strobe_in_select: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !we_b_out |-> !ce_b_out && !dq_oe_b_out)
    else $error("write strobe outside chip select or without data drive");

endmodule // fpecs_flash_cycle

// ### tb/fpecs_flash_model.sv
`timescale 1ns/1ps
module fpecs_flash_model (
  input  wire logic        clk_in,
  input  wire logic [21:0] addr_in,
  input  wire logic [15:0] dq_in,
  input  wire logic        ce_b_in,
  input  wire logic        we_b_in,
  input  wire logic        oe_b_in,
  input  wire logic        reset_b_in,
  output logic [15:0]      dq_out,
  output logic             ready_busy_n_out
);
  logic [15:0] cell_q = 16'hFFFF;
  logic [1:0]  step_q = 2'h0;
  logic        we_p = 1'b1;
  logic        byp_q = 1'b0;
  int          busy_q = 0;
  // write decode on strobe rise, busy countdown
  always @(posedge clk_in) begin
    we_p <= we_b_in;
    if (!reset_b_in) begin
      step_q <= 2'h0;
      busy_q <= 0;
      byp_q  <= 1'b0;
    end else if (busy_q > 0) begin
      busy_q <= busy_q - 1;
    end else if (we_b_in && !we_p && !ce_b_in) begin
      case (step_q)
        2'h0: begin
          step_q <= (dq_in[7:0] == 8'hAA && addr_in[11:0] == 12'h555) ? 2'h1 :
                    (dq_in[7:0] == 8'hA0 && byp_q) ? 2'h3 : 2'h0;
          if (dq_in[7:0] == 8'h90) byp_q <= 1'b0;
        end
        2'h1: step_q <= (dq_in[7:0] == 8'h55 && addr_in[11:0] == 12'h2AA) ? 2'h2 : 2'h0;
        2'h2: begin
          step_q <= (dq_in[7:0] == 8'hA0) ? 2'h3 : 2'h0;
          if (dq_in[7:0] == 8'h20) byp_q <= 1'b1;
        end
        default: begin
          cell_q <= cell_q & dq_in;
          busy_q <= 40;
          step_q <= 2'h0;
        end
      endcase
    end
  end
  // busy pin and polling bit, released bus shows inverse
  assign ready_busy_n_out = (busy_q == 0);
  assign dq_out = oe_b_in ? ~cell_q : (busy_q > 0 ? {8'h00, ~cell_q[7], 7'h00} : cell_q);
endmodule // fpecs_flash_model

// ### tb/fpecs_sequencer_test.sv
`timescale 1ns/1ps
module fpecs_sequencer_test;
  import fpecs_pkg::*;
  logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, ack, busy_seen = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0, rdat, rd;
  logic [21:0] f_addr;
  logic [15:0] f_dq, m_dq, dq_w;
  logic        oe_d, ce, web, oe, rstf, byteb, acc, rdy;
  int          err_count = 0, check_count = 0, cycles = 0;
  always #4 clk = ~clk;
  // bus level from whoever drives it
  assign dq_w = oe_d ? m_dq : f_dq;
  fpecs_sequencer #(.COLLECT_LIMIT(400)) fpecs_sequencer_inst (.CLOCK_IN(clk), .RST_B_IN(rst_b),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .FLASH_ADDR_OUT(f_addr),
    .FLASH_DQ_IN(dq_w), .FLASH_DQ_OUT(f_dq), .FLASH_DQ_OE_B_OUT(oe_d), .FLASH_CE_B_OUT(ce),
    .FLASH_WE_B_OUT(web), .FLASH_OE_B_OUT(oe), .FLASH_RESET_B_OUT(rstf),
    .FLASH_BYTE_B_OUT(byteb), .FLASH_ACCEL_HIGH_OUT(acc), .FLASH_READY_BUSY_N_IN(rdy));
  fpecs_flash_model fpecs_flash_model_inst (.clk_in(clk), .addr_in(f_addr), .dq_in(dq_w),
    .ce_b_in(ce), .we_b_in(web), .oe_b_in(oe), .reset_b_in(rstf), .dq_out(m_dq),
    .ready_busy_n_out(rdy));
  // busy pin watch and hang guard
  always @(posedge clk) begin
    cycles++;
    if (rdy === 1'b0) busy_seen <= 1'b1;
    if (cycles == 40000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  // one classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic op(input logic [31:0] o);
    wb(1'b1, OFS_CMD, o);
    repeat (3000) begin
      wb(1'b0, OFS_STATUS, 32'h0);
      if (rd[1] === 1'b0 && rd[3] === 1'b0) return;
    end
  endtask
  task automatic rdf(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic t_reset();
    rdf(OFS_CTRL);
    chk("ctrl", CTRL_RESET, rd);
    chk1("byte_b", 1'b1, byteb);
    rdf(8'h40);
    chk("unmapped", 32'h0, rd);
    $display("reset test done");
  endtask
  task automatic t_program();
    wb(1'b1, OFS_ADDR, 32'h100);
    wb(1'b1, OFS_DATA, 32'h00F5);
    op(32'd2);
    chk1("busy pin", 1'b1, busy_seen);
    op(32'd0);
    rdf(OFS_DATA);
    chk("programmed", 32'h00F5, {16'h0, rd[15:0]});
    wb(1'b1, OFS_DATA, 32'h0F0F);
    op(32'd2);
    op(32'd0);
    rdf(OFS_DATA);
    chk("zero stays", 32'h0005, {16'h0, rd[15:0]});
    $display("program test done");
  endtask
  task automatic t_refuse();
    wb(1'b1, OFS_CMD, 32'd2);
    wb(1'b1, OFS_CMD, 32'd1);
    rdf(OFS_CMD);
    chk1("busy refuse", 1'b1, rd[4]);
    op(32'd0);
    wb(1'b1, OFS_CMD, 32'd14);
    rdf(OFS_CMD);
    chk1("bad op", 1'b1, rd[4]);
    $display("refuse test done");
  endtask
  task automatic t_modes();
    op(32'd3);
    chk1("bypass on", 1'b1, rd[4]);
    op(32'd5);
    chk1("bypass off", 1'b0, rd[4]);
    op(32'd11);
    chk1("secured on", 1'b1, rd[5]);
    wb(1'b1, OFS_CTRL, 32'h2);
    rdf(OFS_STATUS);
    chk1("no accel", 1'b0, rd[9]);
    chk1("no accel pin", 1'b0, acc);
    wb(1'b1, OFS_CMD, 32'd3);
    rdf(OFS_CMD);
    chk1("no bypass", 1'b1, rd[4]);
    op(32'd12);
    chk1("secured off", 1'b0, rd[5]);
    rdf(OFS_STATUS);
    chk1("accel", 1'b1, rd[9]);
    chk1("accel pin", 1'b1, acc);
    wb(1'b1, OFS_CMD, 32'd7);
    rdf(OFS_CMD);
    chk1("accel bypass only", 1'b1, rd[4]);
    wb(1'b1, OFS_CTRL, 32'h0);
    $display("mode test done");
  endtask
  task automatic t_erase();
    wb(1'b1, OFS_CMD, 32'd6);
    do wb(1'b0, OFS_STATUS, 32'h0); while (rd[3] !== 1'b1);
    wb(1'b1, OFS_CMD, 32'd1);
    rdf(OFS_CMD);
    chk1("erase refuse", 1'b1, rd[4]);
    op(32'd0);
    op(32'd7);
    chk1("window open", 1'b1, rd[6]);
    op(32'd8);
    rdf(OFS_CMD);
    chk1("sector add", 1'b0, rd[4]);
    op(32'd9);
    chk1("suspended", 1'b1, rd[8]);
    chk1("window shut", 1'b0, rd[6]);
    op(32'd10);
    op(32'd7);
    repeat (200) @(posedge clk);
    wb(1'b1, OFS_CMD, 32'd8);
    rdf(OFS_CMD);
    chk1("late add", 1'b1, rd[4]);
    op(32'd1);
    chk1("reset closes", 1'b0, rd[6]);
    $display("erase test done");
  endtask
  task automatic t_bypass();
    op(32'd3);
    wb(1'b1, OFS_DATA, 32'h0004);
    op(32'd4);
    op(32'd0);
    rdf(OFS_DATA);
    chk("bypass program", 32'h0004, {16'h0, rd[15:0]});
    wb(1'b1, OFS_CMD, 32'd13);
    repeat (3) @(posedge clk);
    chk1("reset pin", 1'b0, rstf);
    op(32'd0);
    chk1("reset clears bypass", 1'b0, rd[4]);
    $display("bypass test done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_program();
    t_refuse();
    t_modes();
    t_erase();
    t_bypass();
    stop_test();
  end
endmodule // fpecs_sequencer_test
